/* File: hdl/cet_timer.sv */
/*
 * Cascaded 16-bit event counter / 16-bit PWM timer with an APB slave.
 * Assumes one 100 MHz clock pclk, asynchronous active-low presetn, and an
 * event pin from outside the clock domain.
 */
// How it works
// RL1: Event mode counts one per synchronised falling edge on the event pin.
// RL2: Low and high byte counters act as one 16-bit counter.
// RL3: Event mode count equal to compare raises period pulse and clears count.
// RL4: Source keeps each event pin level at least two machine cycles.
// RL5: Software writes compare low byte, then high byte, never only one.
// RL6: Software keeps initial-value bit zero in event mode.
// RL7: Compare has no buffer; software leaves it alone while running.
// RL8: PWM counter clocks from a prescaler tap or the event pin.
// RL9: PWM count equal to duty inverts the output flop, counting goes on.
// RL10: PWM overflow inverts flop, clears count, raises period pulse.
// RL11: Output flop loads from initial-value bit; reset forces it zero.
// RL12: PWM pin always shows the inverse of the output flop.
// RL13: Duty written while running is held until the next period pulse.
// RL14: Duty written while stopped goes active right after the write.
// RL15: Reading duty returns the active value, not the pending one.
// RL16: Software writes duty low byte, then high byte, never only one.
// RL17: Software sets the port latch of the PWM pin to one.
// RL18: Software writes duty just after the period pulse.
// RL19: Stopping holds the pin; initial bit acts only on later writes.
// RL20: Clearing run stops; then clearing the initial bit drives pin high.
// RL21: Software stops the timer before entering stop mode.
// RL22: PWM period is 65536 source ticks, cleared count up to overflow.
// RL23: Event pin is synchronised before falling-edge detection.
`timescale 1ns/10ps
`default_nettype none

module cet_timer
   import cet_pkg::*;
(
   input wire logic pclk,             // Bus and timer clock
   input wire logic presetn,          // Asynchronous reset, active low
   input wire logic psel,             // APB select
   input wire logic penable,          // APB access phase
   input wire logic pwrite,           // APB write
   input wire logic [7:0] paddr,      // APB byte address
   input wire logic [31:0] pwdata,    // APB write data
   output logic [31:0] prdata,        // APB read data
   output logic pready,               // APB ready
   output logic pslverr,              // APB error on unmapped address
   input wire logic event_input_pin,  // External event / clock pin
   output logic pulse_width_out_pin,  // PWM pin, inverse of output flop
   output logic period_interrupt      // One-cycle period pulse
);

   // ==========================================================
   // State
   cet_ctrl_s ctrl_ff;
   logic [15:0] count_ff, compare_ff, duty_ff, duty_buf_ff;
   logic [7:0] cmp_lo_ff, duty_lo_ff;
   logic duty_pend_ff;
   logic output_toggle_flop_ff;
   logic [CET_PRE_W-1:0] pre_ff;
   logic sync1_ff, sync2_ff, sync3_ff, level_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, pin_ff, irq_ff;

   // ==========================================================
   // Bus decode
   wire logic access = psel & penable;
   wire logic done = access & pready_ff;
   wire logic wr = done & pwrite;
   wire logic hit_ctrl = paddr == CET_OFF_CTRL;
   wire logic hit_clo = paddr == CET_OFF_CMP_LO;
   wire logic hit_chi = paddr == CET_OFF_CMP_HI;
   wire logic hit_dlo = paddr == CET_OFF_DUTY_LO;
   wire logic hit_dhi = paddr == CET_OFF_DUTY_HI;
   wire logic hit_stat = paddr == CET_OFF_STATUS;
   wire logic mapped = hit_ctrl | hit_clo | hit_chi | hit_dlo | hit_dhi |
                       hit_stat;
   wire logic wr_ctrl = wr & hit_ctrl;
   wire logic wr_dhi = wr & hit_dhi;
   wire cet_ctrl_s new_ctrl = cet_ctrl_s'(pwdata[7:0]);
   wire logic [15:0] duty_word = {pwdata[7:0], duty_lo_ff};

   // Duty reads show the active value while a new one waits
   wire logic [31:0] rd_mux =
      hit_ctrl ? {24'h000000, ctrl_ff} :
      hit_clo ? {24'h000000, compare_ff[7:0]} :
      hit_chi ? {24'h000000, compare_ff[15:8]} :
      hit_dlo ? {24'h000000, duty_ff[7:0]} :            // RL15
      hit_dhi ? {24'h000000, duty_ff[15:8]} :            // RL15
      hit_stat ? {15'h0, output_toggle_flop_ff, count_ff} :
      32'h00000000;

   // ==========================================================
   // Event pin: three flops, a level counts once stages two and three agree
   wire logic agree = sync2_ff == sync3_ff;
   wire logic ext_fall = agree & level_ff & ~sync3_ff;   // RL23

   // ==========================================================
   // Tick selection
   logic [CET_PRE_W-1:0] tap;
   always_comb begin
      unique case (ctrl_ff.src)
         CET_SRC_D2048: tap = CET_DIV_2E11;
         CET_SRC_D128: tap = CET_DIV_2E7;
         CET_SRC_D32: tap = CET_DIV_2E5;
         CET_SRC_D8: tap = CET_DIV_2E3;
         CET_SRC_D2: tap = CET_DIV_2E1;
         CET_SRC_EXT, CET_SRC_D1, CET_SRC_D1B: tap = CET_DIV_2E0;
      endcase
   end
   wire logic pre_tick = (pre_ff & tap) == tap;
   wire logic use_ext = ~ctrl_ff.pwm_mode | (ctrl_ff.src == CET_SRC_EXT);
   wire logic tick = ctrl_ff.run_bit &
                     (use_ext ? ext_fall : pre_tick);    // RL1 RL8

   // ==========================================================
   // Counter events
   wire logic [15:0] count_inc = count_ff + 16'h0001;    // RL2
   wire logic ev_match = tick & ~ctrl_ff.pwm_mode &
                         (count_inc == compare_ff);      // RL3
   wire logic ovf = tick & ctrl_ff.pwm_mode &
                    (count_ff == 16'hffff);              // RL10 RL22
   wire logic duty_hit = tick & ctrl_ff.pwm_mode & ~ovf &
                         (count_inc == duty_ff);         // RL9
   wire logic period = ev_match | ovf;

   // Initial bit loads on any control write made while stopped, whether it starts the timer or not
   wire logic init_load = wr_ctrl & ~ctrl_ff.run_bit &
                          ~new_ctrl.run_bit;             // RL19 RL20
   wire logic start = wr_ctrl & ~ctrl_ff.run_bit & new_ctrl.run_bit;
   wire logic flop_toggle = ctrl_ff.pwm_mode & (duty_hit | ovf);
   wire logic nxt_flop =
      (init_load | start) ? new_ctrl.flop_initial_bit :  // RL11
      flop_toggle ? ~output_toggle_flop_ff :             // RL9 RL10
      output_toggle_flop_ff;
   wire logic [15:0] nxt_count =
      (start | period) ? CET_RST_WORD :                  // RL3 RL10
      tick ? count_inc : count_ff;

   // ==========================================================
   // APB slave: one wait state, registered answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & ~mapped;
         if (access & ~pready_ff & ~pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Control and compare; compare writes act at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= cet_ctrl_s'(CET_RST_CTRL);
         compare_ff <= CET_RST_WORD;
         cmp_lo_ff <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= new_ctrl;
         end
         if (wr & hit_clo) begin
            cmp_lo_ff <= pwdata[7:0];
         end
         if (wr & hit_chi) begin
            compare_ff <= {pwdata[7:0], cmp_lo_ff};      // RL7
         end
      end
   end

   // ==========================================================
   // Duty: pending buffer, moved into use at the period; writes made while stopped bypass it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_lo_ff <= 8'h00;
         duty_buf_ff <= CET_RST_WORD;
         duty_ff <= CET_RST_WORD;
         duty_pend_ff <= 1'b0;
      end else begin
         if (wr & hit_dlo) begin
            duty_lo_ff <= pwdata[7:0];
         end
         if (wr_dhi & ~ctrl_ff.run_bit) begin
            duty_ff <= duty_word;                        // RL14
            duty_pend_ff <= 1'b0;
         end else if (wr_dhi) begin
            duty_buf_ff <= duty_word;                    // RL13
            duty_pend_ff <= 1'b1;
         end else if (ovf & duty_pend_ff) begin
            duty_ff <= duty_buf_ff;                      // RL13
            duty_pend_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Prescaler, event synchroniser, counter and output flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_ff <= '0;
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         sync3_ff <= 1'b1;
         level_ff <= 1'b1;
      end else begin
         pre_ff <= pre_ff + 11'h001;
         sync1_ff <= event_input_pin;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (agree) begin
            level_ff <= sync3_ff;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= CET_RST_WORD;
         output_toggle_flop_ff <= 1'b0;                  // RL11
         pin_ff <= 1'b1;
         irq_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         output_toggle_flop_ff <= nxt_flop;
         pin_ff <= ~nxt_flop;                            // RL12
         irq_ff <= period;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pulse_width_out_pin = pin_ff;
   assign period_interrupt = irq_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_evt_step;
      ctrl_ff.run_bit && !ctrl_ff.pwm_mode && ext_fall && !ev_match &&
      !wr_ctrl;
   endsequence

   sequence s_pend_then_ovf;
      duty_pend_ff && ovf && !wr_dhi;
   endsequence

   chk_event_count: assert property ( // RL1
      s_evt_step |=> count_ff == $past(count_ff) + 16'h0001)
      else $error("event edge did not add one count");

   chk_byte_carry: assert property ( // RL2
      tick && !period && !start && count_ff[7:0] == 8'hff |=>
      count_ff[15:8] == $past(count_ff[15:8]) + 8'h01 &&
      count_ff[7:0] == 8'h00)
      else $error("low byte carry lost");

   chk_match_clear: assert property ( // RL3
      ev_match && !wr_ctrl |=> count_ff == 16'h0000 ##0 period_interrupt)
      else $error("compare match did not clear and pulse");

   chk_duty_toggle: assert property ( // RL9
      duty_hit && !wr_ctrl |=>
      output_toggle_flop_ff != $past(output_toggle_flop_ff) &&
      count_ff == $past(count_inc))
      else $error("duty match did not invert the flop");

   chk_ovf_wrap: assert property ( // RL10
      ovf && !wr_ctrl |=> count_ff == 16'h0000 && period_interrupt &&
      output_toggle_flop_ff != $past(output_toggle_flop_ff))
      else $error("overflow did not invert, clear and pulse");

   chk_pin_inverse: assert property ( // RL12
      pulse_width_out_pin == !output_toggle_flop_ff)
      else $error("pin is not inverse of flop");

   chk_duty_load: assert property ( // RL13
      s_pend_then_ovf |=> duty_ff == $past(duty_buf_ff) && !duty_pend_ff)
      else $error("pending duty not loaded at period");

   chk_duty_hold: assert property ( // RL13
      duty_pend_ff && !ovf && !(wr_dhi && !ctrl_ff.run_bit) |=>
      $stable(duty_ff))
      else $error("active duty changed before period");

   chk_stop_load: assert property ( // RL14
      wr_dhi && !ctrl_ff.run_bit |=> duty_ff == $past(duty_word))
      else $error("stopped duty write not taken at once");

   chk_stop_hold: assert property ( // RL19
      (!ctrl_ff.run_bit && !wr_ctrl) [*2] |->
      $stable(output_toggle_flop_ff))
      else $error("stopped flop changed without a write");

   chk_init_load: assert property ( // RL20
      init_load |=> output_toggle_flop_ff == $past(new_ctrl.flop_initial_bit)
      ##0 pulse_width_out_pin == !$past(new_ctrl.flop_initial_bit))
      else $error("initial bit not applied while stopped");

endmodule : cet_timer

`default_nettype wire

/* File: hdl/cet_pkg.sv */
/*
 * Package of the cascaded 16-bit event counter / PWM timer: register
 * offsets, field positions, reset values and the bundled control fields.
 * Assumes an APB host with 32-bit data and byte addresses.
 */
package cet_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CET_OFF_CTRL = 8'h00;
   localparam logic [7:0] CET_OFF_CMP_LO = 8'h04;
   localparam logic [7:0] CET_OFF_CMP_HI = 8'h08;
   localparam logic [7:0] CET_OFF_DUTY_LO = 8'h0c;
   localparam logic [7:0] CET_OFF_DUTY_HI = 8'h10;
   localparam logic [7:0] CET_OFF_STATUS = 8'h14;

   // ==========================================================
   // Control register fields and the status flop bit position
   localparam int CET_BIT_MODE = 0;
   localparam int CET_BIT_RUN = 3;
   localparam int CET_POS_SRC = 4;
   localparam int CET_BIT_INIT = 7;
   localparam int CET_POS_FLOP = 16;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CET_RST_CTRL = 8'h00;
   localparam logic [15:0] CET_RST_WORD = 16'h0000;

   // ==========================================================
   // Prescaler taps, as the mask of low prescaler bits that must all be one for a tick
   localparam int CET_PRE_W = 11;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E11 = 11'h7ff;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E7 = 11'h07f;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E5 = 11'h01f;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E3 = 11'h007;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E1 = 11'h001;
   localparam logic [CET_PRE_W-1:0] CET_DIV_2E0 = 11'h000;

   typedef enum logic [2:0] {
      CET_SRC_D2048 = 3'h0,
      CET_SRC_D128 = 3'h1,
      CET_SRC_D32 = 3'h2,
      CET_SRC_D8 = 3'h3,
      CET_SRC_EXT = 3'h4,
      CET_SRC_D2 = 3'h5,
      CET_SRC_D1 = 3'h6,
      CET_SRC_D1B = 3'h7
   } cet_src_e;

   typedef struct packed {
      logic flop_initial_bit;
      cet_src_e src;
      logic run_bit;
      logic [1:0] spare;
      logic pwm_mode;
   } cet_ctrl_s;

endpackage : cet_pkg

/* File: verification/cet_event_src.sv */
/*
 * Model of the outside source on the timer's event pin.
 * Assumes the bench calls pulses() from just after a pclk rising edge.
 */
`timescale 1ns/10ps
`default_nettype none

module cet_event_src (
   input wire logic pclk,        // Timer clock, used to pace the levels
   output logic event_input_pin  // Event pin, idles high
);
   // ==========================================================
   // Pulse generator
   initial event_input_pin = 1'b1;

   // Six clocks per level keeps well clear of the minimum hold
   task automatic pulses(input int n);
      repeat (n) begin
         event_input_pin <= 1'b0;
         repeat (6) @(posedge pclk);
         event_input_pin <= 1'b1;
         repeat (6) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask
endmodule // cet_event_src

`default_nettype wire

/* File: verification/cet_timer_tb.sv */
/*
 * Self-checking bench of the cascaded event counter / PWM timer.
 * Assumes the design's APB slave and the event source model.
 */
`timescale 1ns/10ps
`default_nettype none

module cet_timer_tb;
   import cet_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, ev_pin, pwm_pin, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic pready, pslverr, er;
   int fails, cmp_count, irq_n;
   time t0, t1;

   cet_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_input_pin(ev_pin), .pulse_width_out_pin(pwm_pin),
      .period_interrupt(irq));
   cet_event_src ev (.pclk(pclk), .event_input_pin(ev_pin));

   // ==========================================================
   // Clock, watchdog, interrupt tally
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      // About 70k cycles of tests, so 95k cycles means a hang
      #950_000;
      fails++;
      print_verdict();
   end
   always @(posedge pclk) begin
      if (irq === 1'b1) irq_n++;
   end

   // ==========================================================
   // Tasks
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge: the next setup never reassigns psel in this time step,
      // and outputs launched by the write have settled on return
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rv);
   endtask
   // Two count captures 64 cycles apart see exactly 64/divider ticks
   task automatic rate(input logic [7:0] c, input logic [31:0] n,
                       input string nm);
      logic [31:0] r0;
      wr(CET_OFF_CTRL, c);
      apb(1'b0, CET_OFF_STATUS, 32'h0);
      r0 = {16'h0, rv[15:0]};
      repeat (60) @(posedge pclk);
      apb(1'b0, CET_OFF_STATUS, 32'h0);
      chk(nm, r0 + n, {16'h0, rv[15:0]});
   endtask
   task automatic wait_pin(input logic lvl, output time t);
      int n;
      n = 0;
      while (pwm_pin !== lvl && n < 70000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 70000) fails++;
      t = $time;
   endtask
   task automatic print_verdict();
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Tests
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("pin_rst", 32'h1, {31'h0, pwm_pin});
      rdc(CET_OFF_CTRL, {24'h0, CET_RST_CTRL}, "ctrl_rst");
      rdc(CET_OFF_STATUS, 32'h0, "stat_rst");
      rdc(8'h18, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, er});
      // PWM: duty written while stopped is active at once
      wr(CET_OFF_CTRL, 8'h01);
      wr(CET_OFF_DUTY_LO, 8'h10);
      wr(CET_OFF_DUTY_HI, 8'h00);
      rdc(CET_OFF_DUTY_LO, 32'h10, "duty_stop");
      wr(CET_OFF_CTRL, 8'h69);
      wait_pin(1'b0, t0);
      wr(CET_OFF_DUTY_LO, 8'h20);
      wr(CET_OFF_DUTY_HI, 8'h00);
      rdc(CET_OFF_DUTY_LO, 32'h10, "duty_run");
      chk("irq_mid", 32'h0, irq_n);
      wait_pin(1'b1, t1);
      chk("hi_span", 32'd65520, 32'((t1 - t0) / 10));
      rdc(CET_OFF_DUTY_LO, 32'h20, "duty_swap");
      chk("irq_ovf", 32'h1, irq_n);
      wait_pin(1'b0, t0);
      chk("lo_span", 32'd32, 32'((t0 - t1) / 10));
      // Stop holds the pin, a later write reloads the flop
      wr(CET_OFF_CTRL, 8'h01);
      apb(1'b0, CET_OFF_STATUS, 32'h0);
      repeat (20) @(posedge pclk);
      rdc(CET_OFF_STATUS, rv, "stat_frozen");
      chk("pin_hold", 32'h0, {31'h0, pwm_pin});
      wr(CET_OFF_CTRL, 8'h01);
      chk("pin_high", 32'h1, {31'h0, pwm_pin});
      wr(CET_OFF_CTRL, 8'h89);
      apb(1'b0, CET_OFF_STATUS, 32'h0);
      chk("flop_init", 32'h1, {31'h0, rv[16]});
      chk("pin_inv", 32'h0, {31'h0, pwm_pin});
      wr(CET_OFF_CTRL, 8'h81);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("pin_rst2", 32'h1, {31'h0, pwm_pin});
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(CET_OFF_CTRL, 32'h0, "ctrl_rst2");
      // PWM clocked from the event pin
      wr(CET_OFF_DUTY_LO, 8'h02);
      wr(CET_OFF_DUTY_HI, 8'h00);
      wr(CET_OFF_CTRL, 8'h49);
      ev.pulses(1);
      chk("ext_one", 32'h1, {31'h0, pwm_pin});
      ev.pulses(1);
      chk("ext_two", 32'h0, {31'h0, pwm_pin});
      // Prescaler taps while running in PWM mode
      rate(8'h39, 32'd8, "rate_d8");
      rate(8'h59, 32'd32, "rate_d2");
      rate(8'h29, 32'd2, "rate_d32");
      // Event counter across the byte carry
      wr(CET_OFF_CTRL, 8'h00);
      wr(CET_OFF_CMP_LO, 8'h02);
      wr(CET_OFF_CMP_HI, 8'h01);
      irq_n = 0;
      wr(CET_OFF_CTRL, 8'h08);
      ev.pulses(257);
      rdc(CET_OFF_STATUS, 32'h0101, "ev_count");
      chk("ev_noirq", 32'h0, irq_n);
      ev.pulses(1);
      rdc(CET_OFF_STATUS, 32'h0, "ev_clear");
      chk("ev_irq", 32'h1, irq_n);
      ev.pulses(1);
      rdc(CET_OFF_STATUS, 32'h1, "ev_resume");
      print_verdict();
   end
endmodule // cet_timer_tb

`default_nettype wire
